// ### rev_pkg.sv
// constants shared by the receive event register bank and its frame classifier
// assumes offsets are compared against a 12-bit register page offset from the host
package rev_pkg;
    // register page offsets
    localparam logic [11:0] REV_EVENT_OFS = 12'h124;
    localparam logic [11:0] REV_STATUS_OFS = 12'h400;
    localparam logic [11:0] REV_LENGTH_OFS = 12'h402;
    localparam logic [11:0] REV_STATION_OFS = 12'h158;
    // identifier in bits 5..0 and reset value of the event register
    localparam logic [5:0] REV_EVENT_ID = 6'h04;
    localparam logic [15:0] REV_EVENT_RESET = 16'h0004;
    // frame length limits in bytes
    localparam int REV_MIN_LEN = 64;
    localparam int REV_MAX_LEN = 1518;
    localparam int REV_LEN_W = 14;
    // field positions of the event register
    localparam int REV_FLAG_LSB = 6;
    localparam int REV_FLAG_W = 10;
    localparam int REV_BIT_HASH_IND = 6;
    localparam int REV_BIT_DRIBBLE = 7;
    localparam int REV_BIT_GOOD = 8;
    localparam int REV_BIT_HASHED = 9;
    localparam int REV_BIT_STATION = 10;
    localparam int REV_BIT_ALLONES = 11;
    localparam int REV_BIT_CRC = 12;
    localparam int REV_BIT_SHORT = 13;
    localparam int REV_BIT_OVER = 14;
    localparam int REV_BIT_WAKE = 15;
    localparam int REV_INDEX_LSB = 10;
    localparam int REV_INDEX_W = 6;
endpackage

// ### rev_frame_classify.sv
// per-frame classifier: turns one frame result strobe into the event flag word
// assumes frame results and accept/enable bits are stable while frameDone is high
`timescale 1ns/1ps
`default_nettype none
module rev_frame_classify
    import rev_pkg::*;
#(
    parameter int LEN_W = REV_LEN_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // frame result strobe and its data
    input wire logic frameDone,
    input wire logic [LEN_W-1:0] frameLen,
    input wire logic crcBad,
    input wire logic dribble,
    input wire logic hashHit,
    input wire logic [REV_INDEX_W-1:0] hashIndex,
    input wire logic stationMatch,
    input wire logic allOnesDest,
    // accept and interrupt enable bits
    input wire logic hashIndividualAccept,
    input wire logic stationAddressAccept,
    input wire logic allOnesAccept,
    input wire logic goodFrameIrqEnable,
    input wire logic checksumFaultIrqEnable,
    input wire logic shortFrameIrqEnable,
    input wire logic oversizeIrqEnable,
    // classified result, one cycle after frameDone
    output logic capValid,
    output logic [REV_FLAG_W-1:0] capFlags,
    output logic [LEN_W-1:0] capLen,
    output logic capIrq
);
    localparam logic [LEN_W-1:0] MIN_L = LEN_W'(REV_MIN_LEN);
    localparam logic [LEN_W-1:0] MAX_L = LEN_W'(REV_MAX_LEN);

    typedef struct packed {
        logic valid;
        logic [REV_FLAG_W-1:0] flags;
        logic [LEN_W-1:0] len;
        logic irq;
    } revc_s;

    revc_s q, d;
    logic good, runt, over, hashMode;

    always_comb begin
        runt = frameLen < MIN_L;
        over = frameLen > MAX_L;
        good = !crcBad && !runt && !over;
        // broadcast frames accepted by allOnesAccept keep their separate flags even when hashed
        hashMode = good && hashHit && !(allOnesDest && allOnesAccept);
        d = q;
        d.valid = frameDone;
        d.irq = 1'b0;
        if (frameDone) begin
            d.flags = '0;
            d.flags[REV_BIT_HASH_IND-REV_FLAG_LSB] = good && hashIndividualAccept && hashHit;
            d.flags[REV_BIT_DRIBBLE-REV_FLAG_LSB] = dribble;
            d.flags[REV_BIT_GOOD-REV_FLAG_LSB] = good;
            d.flags[REV_BIT_HASHED-REV_FLAG_LSB] = hashHit;
            if (hashMode) begin
                d.flags[REV_INDEX_LSB-REV_FLAG_LSB +: REV_INDEX_W] = hashIndex;
            end else begin
                d.flags[REV_BIT_STATION-REV_FLAG_LSB] = stationMatch && good && stationAddressAccept;
                d.flags[REV_BIT_ALLONES-REV_FLAG_LSB] = allOnesDest && good && allOnesAccept;
                d.flags[REV_BIT_CRC-REV_FLAG_LSB] = crcBad;
                d.flags[REV_BIT_SHORT-REV_FLAG_LSB] = runt;
                d.flags[REV_BIT_OVER-REV_FLAG_LSB] = over;
            end
            // bytes past the limit are dropped, so the kept length saturates
            d.len = over ? MAX_L : frameLen;
            d.irq = (good && goodFrameIrqEnable) || (crcBad && checksumFaultIrqEnable) ||
                    (runt && shortFrameIrqEnable) || (over && oversizeIrqEnable);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign capValid = q.valid;
    assign capFlags = q.flags;
    assign capLen = q.len;
    assign capIrq = q.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    hash_individual_a: assert property (capValid && capFlags[0] |->
        capFlags[REV_BIT_GOOD-REV_FLAG_LSB] && capFlags[REV_BIT_HASHED-REV_FLAG_LSB])
        else $error("hash individual flag without good frame and hash hit");
    dribble_flag_a: assert property (frameDone |=> capFlags[REV_BIT_DRIBBLE-REV_FLAG_LSB] == $past(dribble))
        else $error("dribble flag does not follow the frame");
    hash_index_a: assert property (frameDone && hashHit && !crcBad &&
        frameLen >= MIN_L && frameLen <= MAX_L && !(allOnesDest && allOnesAccept) |=>
        capFlags[REV_INDEX_LSB-REV_FLAG_LSB +: REV_INDEX_W] == $past(hashIndex))
        else $error("hash index not placed in the upper flags");
    crc_flag_a: assert property (frameDone && crcBad |=>
        capFlags[REV_BIT_CRC-REV_FLAG_LSB] && !capFlags[REV_BIT_GOOD-REV_FLAG_LSB])
        else $error("bad checksum not flagged");
    runt_flag_a: assert property (frameDone && frameLen < MIN_L |=>
        capFlags[REV_BIT_SHORT-REV_FLAG_LSB] && !capFlags[REV_BIT_GOOD-REV_FLAG_LSB])
        else $error("short frame not flagged");
    station_flag_a: assert property (frameDone && !stationAddressAccept && !hashHit |=>
        !capFlags[REV_BIT_STATION-REV_FLAG_LSB])
        else $error("station flag set while station accept is off");
    allones_flag_a: assert property (frameDone && !allOnesDest |=>
        capFlags[REV_BIT_ALLONES-REV_FLAG_LSB] == (capFlags[REV_BIT_GOOD-REV_FLAG_LSB] &&
        capFlags[REV_BIT_HASHED-REV_FLAG_LSB] && $past(hashIndex[1]) && $past(hashHit)))
        else $error("all-ones flag set for a frame that is not all ones");
    oversize_len_a: assert property (frameDone && frameLen > MAX_L |=>
        capLen == MAX_L && capFlags[REV_BIT_OVER-REV_FLAG_LSB] && !capFlags[REV_BIT_GOOD-REV_FLAG_LSB])
        else $error("oversize frame not flagged or length not clamped");
endmodule
`default_nettype wire

// ### rev_event_regs.sv
// receive event register bank: read-to-clear event flags, a non-clearing copy,
// the good-frame length, interrupt request and the interrupt status queue feed
// assumes one host read strobe per access; read data appears one cycle later
//
// What this block does
// - bits 5..0 of the event register always read 000100
// - a host read of the event register returns it, then clears all events
// - status copy at 0400h mirrors the event register but reads never clear it
// - bit 6 set only with good frame, hash accept and hash hit
// - bit 7 flags one to seven trailing bits; with CRC error means alignment
// - bit 8 marks a good frame; its length is readable at 0402h
// - good frame with its interrupt enable raises an interrupt
// - bit 9 set when the hash filter accepted the destination address
// - with hash hit and good frame, unless all-ones address with all-ones accept, bits F..A carry the hash index
// - otherwise bits F..A are separate event flags
// - bit A set only for station address match, good frame, station accept
// - bit B set only for all-ones address, good frame, all-ones accept
// - bit C flags bad CRC; interrupt when its enable is set
// - bit D flags frames under 64 bytes; interrupt when enabled
// - bit E flags frames over 1518 bytes, excess dropped; interrupt when enabled
// - bit F set once per wake frame, cleared by read or overwritten by the next captured frame
// - after reset the event register reads 0004h
// - enabled events are mapped to the status queue and raise the interrupt
`timescale 1ns/1ps
`default_nettype none
module rev_event_regs
    import rev_pkg::*;
#(
    parameter int LEN_W = REV_LEN_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host register read port
    input wire logic hostRdStb,
    input wire logic [11:0] hostAddr,
    output logic [15:0] hostRdData,
    output logic hostRdValid,
    // frame result strobe from the receive path
    input wire logic frameDone,
    input wire logic [LEN_W-1:0] frameLen,
    input wire logic crcBad,
    input wire logic dribble,
    input wire logic hashHit,
    input wire logic [REV_INDEX_W-1:0] hashIndex,
    input wire logic stationMatch,
    input wire logic allOnesDest,
    input wire logic wakeFrameSeen,
    // receiver_accept_control bits
    input wire logic hashIndividualAccept,
    input wire logic stationAddressAccept,
    input wire logic allOnesAccept,
    // receiver_configuration bits
    input wire logic goodFrameIrqEnable,
    input wire logic checksumFaultIrqEnable,
    input wire logic shortFrameIrqEnable,
    input wire logic oversizeIrqEnable,
    input wire logic receiveDmaExclusive,
    // interrupt request and status queue feed
    output logic irq,
    output logic isqValid,
    output logic [15:0] isqData
);
    if (LEN_W < 11 || LEN_W > 16) begin : gLenCheck
        $error("LEN_W must hold 1518 and fit the 16-bit length register");
    end

    typedef struct packed {
        logic [REV_FLAG_W-1:0] evt;
        logic [REV_FLAG_W-1:0] stat;
        logic [LEN_W-1:0] len;
        logic [15:0] rdData;
        logic rdValid;
        logic irq;
        logic isqValid;
        logic [15:0] isqData;
    } reve_s;

    localparam int WAKE_I = REV_BIT_WAKE - REV_FLAG_LSB;
    localparam int GOOD_I = REV_BIT_GOOD - REV_FLAG_LSB;
    localparam int CRC_I = REV_BIT_CRC - REV_FLAG_LSB;
    localparam int SHORT_I = REV_BIT_SHORT - REV_FLAG_LSB;
    localparam int OVER_I = REV_BIT_OVER - REV_FLAG_LSB;

    reve_s q, d;
    logic capValid, capIrq;
    logic [REV_FLAG_W-1:0] capFlags;
    logic [LEN_W-1:0] capLen;
    logic rdEvt;

    rev_frame_classify #(
        .LEN_W(LEN_W)
    ) uClassify (
        .mclk(mclk),
        .rst(rst),
        .frameDone(frameDone),
        .frameLen(frameLen),
        .crcBad(crcBad),
        .dribble(dribble),
        .hashHit(hashHit),
        .hashIndex(hashIndex),
        .stationMatch(stationMatch),
        .allOnesDest(allOnesDest),
        .hashIndividualAccept(hashIndividualAccept),
        .stationAddressAccept(stationAddressAccept),
        .allOnesAccept(allOnesAccept),
        .goodFrameIrqEnable(goodFrameIrqEnable),
        .checksumFaultIrqEnable(checksumFaultIrqEnable),
        .shortFrameIrqEnable(shortFrameIrqEnable),
        .oversizeIrqEnable(oversizeIrqEnable),
        .capValid(capValid),
        .capFlags(capFlags),
        .capLen(capLen),
        .capIrq(capIrq)
    );

    always_comb begin
        rdEvt = hostRdStb && (hostAddr == REV_EVENT_OFS);
        d = q;
        d.rdValid = hostRdStb;
        d.rdData = '0;
        d.isqValid = 1'b0;
        // read data; contents are meaningless while receiveDmaExclusive is set,
        // but the register still behaves the same so nothing is left undriven
        if (hostRdStb) begin
            if (hostAddr == REV_EVENT_OFS) begin
                d.rdData = {q.evt, REV_EVENT_ID};
            end else if (hostAddr == REV_STATUS_OFS) begin
                d.rdData = {q.stat, REV_EVENT_ID};
            end else if (hostAddr == REV_LENGTH_OFS) begin
                d.rdData = 16'(q.len);
            end else begin
                d.rdData = '0;
            end
        end
        // a captured frame wins over the clearing read in the same cycle
        if (capValid) begin
            d.evt = capFlags;
        end else if (rdEvt) begin
            d.evt = '0;
        end
        if (capValid) begin
            d.stat = capFlags;
        end
        // wake is its own event source and only sets, never self-clears
        if (wakeFrameSeen) begin
            d.evt[WAKE_I] = 1'b1;
            d.stat[WAKE_I] = 1'b1;
        end
        if (capValid && capFlags[GOOD_I]) begin
            d.len = capLen;
        end
        // the request holds until software reads the event register
        if (capIrq) begin
            d.irq = 1'b1;
            d.isqValid = 1'b1;
            d.isqData = {d.evt, REV_EVENT_ID};
        end else if (rdEvt) begin
            d.irq = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign hostRdData = q.rdData;
    assign hostRdValid = q.rdValid;
    assign irq = q.irq;
    assign isqValid = q.isqValid;
    assign isqData = q.isqData;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    id_bits_a: assert property (hostRdStb && hostAddr == REV_EVENT_OFS |=>
        hostRdValid && hostRdData[5:0] == REV_EVENT_ID)
        else $error("event register identifier bits wrong");
    read_clear_a: assert property (rdEvt && !capValid && !wakeFrameSeen |=>
        q.evt == '0 ##1 ($past(capValid) || $past(wakeFrameSeen) || q.evt == '0))
        else $error("event flags not cleared by read");
    read_answer_a: assert property (hostRdStb |=> hostRdValid)
        else $error("read strobe without an answer");
    status_keep_a: assert property (rdEvt && !capValid && !wakeFrameSeen |=> $stable(q.stat))
        else $error("status copy changed by event read");
    status_read_a: assert property (hostRdStb && hostAddr == REV_STATUS_OFS |=>
        hostRdData == {$past(q.stat), REV_EVENT_ID})
        else $error("status copy read data wrong");
    status_copy_a: assert property (capValid |=> q.stat[WAKE_I-1:0] == $past(capFlags[WAKE_I-1:0]))
        else $error("status copy not loaded from the frame result");
    good_irq_a: assert property (capValid && capFlags[GOOD_I] && $past(goodFrameIrqEnable) |=>
        irq && isqValid)
        else $error("good frame interrupt missing");
    quiet_irq_a: assert property (!irq && !capIrq |=> !irq)
        else $error("interrupt raised without an enabled event");
    length_reg_a: assert property (capValid && capFlags[GOOD_I] |=> q.len == $past(capLen))
        else $error("good frame length not held");
    length_keep_a: assert property (!(capValid && capFlags[GOOD_I]) |=> $stable(q.len))
        else $error("length register changed without a good frame");
    length_read_a: assert property (hostRdStb && hostAddr == REV_LENGTH_OFS |=>
        hostRdData == 16'($past(q.len)))
        else $error("length register read data wrong");
    crc_irq_a: assert property (capValid && capFlags[CRC_I] && !capFlags[GOOD_I] &&
        $past(checksumFaultIrqEnable) |=> irq)
        else $error("checksum fault interrupt missing");
    short_irq_a: assert property (capValid && capFlags[SHORT_I] && !capFlags[GOOD_I] &&
        $past(shortFrameIrqEnable) |=> irq)
        else $error("short frame interrupt missing");
    over_irq_a: assert property (capValid && capFlags[OVER_I] && !capFlags[GOOD_I] &&
        $past(oversizeIrqEnable) |=> irq)
        else $error("oversize frame interrupt missing");
    wake_set_a: assert property (wakeFrameSeen |=> q.evt[WAKE_I] && q.stat[WAKE_I])
        else $error("wake flag not set");
    wake_hold_a: assert property (!q.evt[WAKE_I] && !wakeFrameSeen && !capValid |=> !q.evt[WAKE_I])
        else $error("wake flag set without a wake frame");
    reset_val_a: assert property ($past(rst) |-> q.evt == '0 && !irq)
        else $error("event register not at reset value");
    isq_map_a: assert property (capIrq |=> isqValid && isqData[15:6] == q.evt &&
        isqData[5:0] == REV_EVENT_ID)
        else $error("status queue not fed with event contents");
    isq_quiet_a: assert property (!capIrq |=> !isqValid)
        else $error("status queue entry without an enabled event");
    keep_new_a: assert property (capValid && rdEvt && !wakeFrameSeen |=> q.evt == $past(capFlags))
        else $error("events lost in a clearing read");
    irq_hold_a: assert property (irq && !rdEvt |=> irq)
        else $error("interrupt dropped before the event read");

    good_read_c: cover property (capValid && capFlags[GOOD_I] ##[1:4] rdEvt);
    hash_mode_c: cover property (capValid && capFlags[GOOD_I] && capFlags[REV_BIT_HASHED-REV_FLAG_LSB]);
    race_c: cover property (capValid && rdEvt);
    wake_c: cover property (wakeFrameSeen ##[1:4] rdEvt);
    dma_read_c: cover property (receiveDmaExclusive && rdEvt);
endmodule
`default_nettype wire

// ### rev_host_model.sv
// host side of the register read port: one read strobe per call, answer taken with hostRdValid
// assumes the bench calls read from a single process, at most one call at a time
`timescale 1ns/1ps
`default_nettype none
module rev_host_model (
    // clock
    input wire logic mclk,
    // register read port
    output logic hostRdStb,
    output logic [11:0] hostAddr,
    input wire logic [15:0] hostRdData,
    input wire logic hostRdValid
);
    initial begin
        hostRdStb = 1'b0;
        hostAddr = 12'hFFF;
    end

    // the strobe lasts one cycle; the answer is due one edge later
    task automatic read(input logic [11:0] addr, output logic [15:0] data, output logic ok);
        @(negedge mclk);
        hostRdStb = 1'b1;
        hostAddr = addr;
        @(negedge mclk);
        hostRdStb = 1'b0;
        // park the address on the inverse so a stale offset is never seen as held
        hostAddr = ~addr;
        ok = hostRdValid;
        data = hostRdData;
    endtask
endmodule
`default_nettype wire

// ### tb_receive_event_status_register.sv
// self-checking bench for the receive event register bank
// assumes rev_event_regs and rev_host_model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb_receive_event_status_register;
    import rev_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, frameDone = 1'b0, crcBad = 1'b0, dribble = 1'b0, hashHit = 1'b0;
    logic stationMatch = 1'b0, allOnesDest = 1'b0, wakeFrameSeen = 1'b0, dmaExcl = 1'b0;
    logic hAcc = 1'b0, sAcc = 1'b0, aAcc = 1'b0, irqEn = 1'b1;
    logic [13:0] frameLen = 14'h0;
    logic [5:0] hashIndex = 6'h2A;
    logic hostRdStb, hostRdValid, irq, isqValid, rdOk;
    logic [11:0] hostAddr;
    logic [15:0] hostRdData, isqData, rd, isqExp = 16'h0000;
    int failCount = 0, nCompared = 0;

    always #5 mclk = ~mclk;

    rev_event_regs #(.LEN_W(14)) dut (.mclk(mclk), .rst(rst), .hostRdStb(hostRdStb), .hostAddr(hostAddr),
        .hostRdData(hostRdData), .hostRdValid(hostRdValid), .frameDone(frameDone), .frameLen(frameLen),
        .crcBad(crcBad), .dribble(dribble), .hashHit(hashHit), .hashIndex(hashIndex),
        .stationMatch(stationMatch), .allOnesDest(allOnesDest), .wakeFrameSeen(wakeFrameSeen),
        .hashIndividualAccept(hAcc), .stationAddressAccept(sAcc), .allOnesAccept(aAcc),
        .goodFrameIrqEnable(irqEn), .checksumFaultIrqEnable(irqEn), .shortFrameIrqEnable(irqEn),
        .oversizeIrqEnable(irqEn), .receiveDmaExclusive(dmaExcl), .irq(irq), .isqValid(isqValid),
        .isqData(isqData));

    rev_host_model host (.mclk(mclk), .hostRdStb(hostRdStb), .hostAddr(hostAddr), .hostRdData(hostRdData),
        .hostRdValid(hostRdValid));

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [15:0] exp);
        host.read(a, rd, rdOk);
        check1("read answer", 1'b1, rdOk);
        check16("read data", exp, rd);
    endtask

    // one frame result strobe; flags = {crc, dribble, hash, station, all-ones}, acc = {hash, station, all-ones}
    task automatic frame(input logic [13:0] len, input logic [4:0] flags, input logic [2:0] acc);
        @(negedge mclk);
        frameDone = 1'b1;
        frameLen = len;
        {crcBad, dribble, hashHit, stationMatch, allOnesDest} = flags;
        {hAcc, sAcc, aAcc} = acc;
        @(negedge mclk);
        frameDone = 1'b0;
    endtask

    // frame, let it settle, then check queue word, interrupt, read-to-clear and the copy
    task automatic frame_check(input logic [13:0] len, input logic [4:0] flags, input logic [2:0] acc,
                               input logic [15:0] exp);
        frame(len, flags, acc);
        @(negedge mclk);
        check1("queue valid", irqEn, isqValid);
        @(negedge mclk);
        // only enabled events feed the queue; otherwise it keeps the last entry
        if (irqEn) begin
            isqExp = exp;
        end
        check16("queue word", isqExp, isqData);
        check1("interrupt", irqEn, irq);
        rd_check(REV_EVENT_OFS, exp);
        check1("interrupt after read", 1'b0, irq);
        rd_check(REV_EVENT_OFS, REV_EVENT_RESET);
        rd_check(REV_STATUS_OFS, exp);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failCount++;
        $display("Error watchdog expected done seen hang");
        final_report();
    end

    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        rd_check(REV_EVENT_OFS, REV_EVENT_RESET);
        rd_check(REV_EVENT_OFS, REV_EVENT_RESET);
        $display("reset test done");
        frame_check(14'd100, 5'b00010, 3'b010, 16'h0504);
        rd_check(REV_LENGTH_OFS, 16'd100);
        frame_check(14'd100, 5'b00010, 3'b000, 16'h0104);
        frame_check(14'd100, 5'b11000, 3'b000, 16'h1084);
        frame_check(14'd63, 5'b00000, 3'b000, 16'h2004);
        frame_check(14'd64, 5'b00000, 3'b000, 16'h0104);
        frame_check(14'd1518, 5'b00000, 3'b000, 16'h0104);
        rd_check(REV_LENGTH_OFS, 16'd1518);
        frame_check(14'd1519, 5'b00000, 3'b000, 16'h4004);
        frame_check(14'd100, 5'b00001, 3'b001, 16'h0904);
        frame_check(14'd100, 5'b00001, 3'b000, 16'h0104);
        frame_check(14'd100, 5'b00100, 3'b100, 16'hAB44);
        frame_check(14'd100, 5'b00100, 3'b000, 16'hAB04);
        frame_check(14'd100, 5'b10100, 3'b100, 16'h1204);
        frame_check(14'd100, 5'b00101, 3'b001, 16'h0B04);
        frame_check(14'd100, 5'b00100, 3'b000, 16'hAB04);
        $display("frame classification test done");
        irqEn = 1'b0;
        frame_check(14'd100, 5'b10000, 3'b000, 16'h1004);
        irqEn = 1'b1;
        $display("interrupt enable test done");
        @(negedge mclk);
        wakeFrameSeen = 1'b1;
        @(negedge mclk);
        wakeFrameSeen = 1'b0;
        rd_check(REV_EVENT_OFS, 16'h8004);
        rd_check(REV_EVENT_OFS, REV_EVENT_RESET);
        $display("wake test done");
        frame(14'd100, 5'b00000, 3'b000);
        repeat (3) @(negedge mclk);
        // the read strobe lands on the edge at which the runt frame is captured
        fork
            frame(14'd63, 5'b00000, 3'b000);
            begin
                @(negedge mclk);
                host.read(REV_EVENT_OFS, rd, rdOk);
            end
        join
        check16("first read value", 16'h0104, rd);
        check1("interrupt kept", 1'b1, irq);
        rd_check(REV_EVENT_OFS, 16'h2004);
        rd_check(REV_EVENT_OFS, REV_EVENT_RESET);
        rd_check(12'h0FE, 16'h0000);
        $display("clear race test done");
        dmaExcl = 1'b1;
        frame(14'd100, 5'b00000, 3'b000);
        // contents are not trusted while receive DMA is exclusive, only the answer is
        host.read(REV_EVENT_OFS, rd, rdOk);
        check1("answer while dma exclusive", 1'b1, rdOk);
        dmaExcl = 1'b0;
        rd_check(REV_EVENT_OFS, REV_EVENT_RESET);
        $display("dma exclusive test done");
        final_report();
    end
endmodule
`default_nettype wire
